// ### inc/tcap_pkg.sv
// Purpose: constants and types for the capture timer block
// Assumes: 8-bit register port, byte addresses as printed
// Notes: main timer registers sit at offsets chosen for this block
package tcap_pkg;
    localparam logic [7:0] TCAP_ADDR_MAIN_MODE = 8'h00_FA;
    localparam logic [7:0] TCAP_ADDR_MAIN_LOW = 8'h00_FB;
    localparam logic [7:0] TCAP_ADDR_MAIN_HIGH = 8'h00_FC;
    localparam logic [7:0] TCAP_ADDR_CAP_MODE = 8'h00_FD;
    localparam logic [7:0] TCAP_ADDR_CAP_LOW = 8'h00_FE;
    localparam logic [7:0] TCAP_ADDR_CAP_HIGH = 8'h00_FF;
    localparam logic [7:0] TCAP_ADDR_FLAGS = 8'h00_F9;
    // main mode fields
    localparam int TCAP_MM_ENABLE = 7;
    localparam int TCAP_MM_RATE_LSB = 4;
    localparam int TCAP_MM_SRC = 3;
    // capture mode fields
    localparam int TCAP_CM_ENABLE = 7;
    localparam int TCAP_CM_OVSEL = 3;
    localparam int TCAP_CM_GO = 2;
    localparam int TCAP_CM_FSEL_LSB = 0;
    // flag register fields
    localparam int TCAP_FL_FLAG = 0;
    localparam int TCAP_FL_IEN = 1;
    localparam logic [7:0] TCAP_RESET_BYTE = 8'h00_00;
    localparam logic [15:0] TCAP_RESET_WORD = 16'h0000;
    localparam logic [15:0] TCAP_FULL_SCALE = 16'hFFFF;
    localparam logic [7:0] TCAP_MM_MASK = 8'h00_F8;
    localparam logic [7:0] TCAP_CM_MASK = 8'h00_8F;
    localparam logic [6:0] TCAP_PRE_RESET = 7'h00;
    typedef enum logic [1:0] {
        TCAP_FN_CONT,
        TCAP_FN_HIGH,
        TCAP_FN_LOW,
        TCAP_FN_CYCLE
    } tcap_fn_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcap_bus_t;
endpackage

// ### src/tcap_timer.sv
// Purpose: 16-bit up timer with capture/measurement on one input pin
// Assumes: inputs synchronous to mclk_in; cpu and hosc ticks are
//          one-cycle enables from the clock system
// Notes: 8-bit register port, read data valid the cycle after strobe
//
// Overview of operation
// R1: capture works only with both enables set
// R2: function select picks continuous/high/low/cycle
// R3: go waits start edge, counts, stops, flags
// R4: continuous mode: both counters idle until rise
// R5: capture counter advances on input rising edges
// R6: overflow select 0 ends on capture wrap
// R7: overflow select 1 ends on main wrap
// R8: high mode: rise starts, fall stops
// R9: go while high skips current high pulse
// R10: low mode: fall starts, rise stops
// R11: go while low skips current low pulse
// R12: cycle mode: rise starts, next rise stops
// R13: cycle mode mid-pulse waits next rising edge
// R14: flag with enable requests timer interrupt
// R15: mode register bits layout, reset zero
// R16: go reads one while waiting or counting
// R17: high byte held, low write loads both
// R18: low read latches high byte snapshot
// R19: software preloads counters for duration
// R20: software preloads counters for edge count
// R21: main counter ticks prescaled, wrap sets flag
// R22: clock source select and 3-bit prescale select
// R23: input synchronised, edges from synced samples
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tcap_timer
    import tcap_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic cpu_tick_in,
    input wire logic hosc_tick_in,
    input wire logic capture_input_pin_in,
    input wire logic [7:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [7:0] bus_rdata_out,
    output logic irq_out
);
    typedef enum logic [1:0] {
        TCAP_ST_IDLE,
        TCAP_ST_WAIT,
        TCAP_ST_RUN
    } tcap_st_t;

    tcap_bus_t bus;
    assign bus.addr = bus_addr_in;
    assign bus.wdata = bus_wdata_in;
    assign bus.wr = bus_wr_in;
    assign bus.rd = bus_rd_in;

    logic [7:0] main_mode;
    logic capture_enable;
    logic capture_overflow_select;
    logic [1:0] capture_function_select;
    logic capture_go;
    logic main_timer_flag;
    logic main_timer_irq_enable;
    logic [15:0] main_count;
    logic [15:0] capture_count;
    logic [7:0] main_high_hold;
    logic [7:0] cap_high_hold;
    logic [7:0] main_high_snap;
    logic [7:0] cap_high_snap;
    logic [6:0] prescale;
    logic sync_a;
    logic sync_b;
    logic pin_prev;
    tcap_st_t state;

    wire main_timer_enable = main_mode[TCAP_MM_ENABLE];
    wire [2:0] main_prescale_select = main_mode[6:4];
    wire main_clock_source_select = main_mode[TCAP_MM_SRC];
    wire active = main_timer_enable && capture_enable; // R1
    wire rise = sync_b && !pin_prev; // R23
    wire fall = !sync_b && pin_prev; // R23
    wire wr_mm = bus.wr && bus.addr == TCAP_ADDR_MAIN_MODE;
    wire wr_ml = bus.wr && bus.addr == TCAP_ADDR_MAIN_LOW;
    wire wr_mh = bus.wr && bus.addr == TCAP_ADDR_MAIN_HIGH;
    wire wr_cm = bus.wr && bus.addr == TCAP_ADDR_CAP_MODE;
    wire wr_cl = bus.wr && bus.addr == TCAP_ADDR_CAP_LOW;
    wire wr_ch = bus.wr && bus.addr == TCAP_ADDR_CAP_HIGH;
    wire wr_fl = bus.wr && bus.addr == TCAP_ADDR_FLAGS;
    wire rd_ml = bus.rd && bus.addr == TCAP_ADDR_MAIN_LOW;
    wire rd_cl = bus.rd && bus.addr == TCAP_ADDR_CAP_LOW;

    // input synchroniser; only sync_b is looked at
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            sync_a <= capture_input_pin_in; // R23
            sync_b <= sync_a;
            pin_prev <= sync_b;
        end
    end

    // prescaler: select 000 divides by 128, 111 by 1
    logic src_tick;
    logic main_tick;
    logic [6:0] pre_mask;
    always_comb begin
        src_tick = main_clock_source_select ? hosc_tick_in
                                            : cpu_tick_in; // R22
        pre_mask = 7'h7F >> main_prescale_select; // R22
        main_tick = main_timer_enable && src_tick
                    && ((prescale & pre_mask) == pre_mask);
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prescale <= TCAP_PRE_RESET;
        end else if (!main_timer_enable) begin
            prescale <= TCAP_PRE_RESET;
        end else if (src_tick) begin
            prescale <= prescale + 7'h01; // R22
        end
    end

    // measurement sequencer
    logic start_ev;
    logic stop_ev;
    logic main_wrap;
    logic cap_wrap;
    logic cap_step;
    logic main_step;
    tcap_fn_t fn;
    always_comb begin
        fn = tcap_fn_t'(capture_function_select); // R2
        start_ev = 1'b0;
        unique case (fn)
            TCAP_FN_CONT: start_ev = rise; // R4
            TCAP_FN_HIGH: start_ev = rise; // R8 R9
            TCAP_FN_LOW: start_ev = fall; // R10 R11
            TCAP_FN_CYCLE: start_ev = rise; // R12 R13
        endcase
        // counting only in run; timer free-runs when capture is off
        main_step = main_tick && (!active || state == TCAP_ST_RUN); // R4
        // the start edge is itself the first counted edge
        cap_step = active && fn == TCAP_FN_CONT && rise
                   && (state == TCAP_ST_RUN
                       || state == TCAP_ST_WAIT); // R4 R5
        main_wrap = main_step && main_count == TCAP_FULL_SCALE; // R21
        cap_wrap = cap_step && capture_count == TCAP_FULL_SCALE;
        stop_ev = 1'b0;
        unique case (fn)
            TCAP_FN_CONT: stop_ev = capture_overflow_select ? main_wrap
                                                            : cap_wrap;
            TCAP_FN_HIGH: stop_ev = fall; // R8
            TCAP_FN_LOW: stop_ev = rise; // R10
            TCAP_FN_CYCLE: stop_ev = rise; // R12
        endcase
    end

    wire done = active && state == TCAP_ST_RUN && stop_ev; // R3
    wire go_set = wr_cm && bus.wdata[TCAP_CM_GO];

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= TCAP_ST_IDLE;
        end else if (!active) begin
            state <= TCAP_ST_IDLE; // R1
        end else begin
            unique case (state)
                TCAP_ST_IDLE: if (go_set) state <= TCAP_ST_WAIT; // R3
                TCAP_ST_WAIT: if (start_ev) state <= TCAP_ST_RUN; // R3
                TCAP_ST_RUN: if (done) state <= TCAP_ST_IDLE; // R3
            endcase
        end
    end

    // capture mode register; done clears go
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            capture_enable <= 1'b0;
            capture_overflow_select <= 1'b0;
            capture_function_select <= 2'b00;
            capture_go <= 1'b0;
        end else begin
            if (wr_cm) begin
                capture_enable <= bus.wdata[TCAP_CM_ENABLE]; // R15
                capture_overflow_select <= bus.wdata[TCAP_CM_OVSEL];
                capture_function_select <= bus.wdata[1:0];
            end
            if (done) begin
                capture_go <= 1'b0; // R3 R16
            end else if (wr_cm) begin
                capture_go <= bus.wdata[TCAP_CM_GO] && active;
            end else if (state == TCAP_ST_IDLE && !go_set) begin
                capture_go <= capture_go && active;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            main_mode <= TCAP_RESET_BYTE;
        end else if (wr_mm) begin
            main_mode <= bus.wdata & TCAP_MM_MASK;
        end
    end

    // flag: hardware set wins over software clear
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            main_timer_flag <= 1'b0;
            main_timer_irq_enable <= 1'b0;
        end else begin
            if (wr_fl) begin
                main_timer_irq_enable <= bus.wdata[TCAP_FL_IEN];
            end
            if (main_wrap || done) begin
                main_timer_flag <= 1'b1; // R21 R3
            end else if (wr_fl && !bus.wdata[TCAP_FL_FLAG]) begin
                main_timer_flag <= 1'b0; // R21
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= main_timer_flag && main_timer_irq_enable; // R14
        end
    end

    // main counter; high byte held until low write
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            main_count <= TCAP_RESET_WORD;
            main_high_hold <= TCAP_RESET_BYTE;
        end else begin
            if (wr_mh) begin
                main_high_hold <= bus.wdata;
            end
            if (wr_ml) begin
                main_count <= {main_high_hold, bus.wdata};
            end else if (main_step) begin
                // stop tick still counts; a wrap lands on zero
                main_count <= main_count + 16'h0001; // R21 R7
            end
        end
    end

    // capture counter, same byte pairing
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            capture_count <= TCAP_RESET_WORD;
            cap_high_hold <= TCAP_RESET_BYTE;
        end else begin
            if (wr_ch) begin
                cap_high_hold <= bus.wdata; // R17
            end
            if (wr_cl) begin
                capture_count <= {cap_high_hold, bus.wdata}; // R17
            end else if (cap_step) begin
                capture_count <= capture_count + 16'h0001; // R5 R6
            end
        end
    end

    // low-byte reads freeze the high byte for a consistent pair
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            main_high_snap <= TCAP_RESET_BYTE;
            cap_high_snap <= TCAP_RESET_BYTE;
        end else begin
            if (rd_ml) begin
                main_high_snap <= main_count[15:8];
            end
            if (rd_cl) begin
                cap_high_snap <= capture_count[15:8]; // R18
            end
        end
    end

    // read port; unmapped addresses read zero
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_rdata_out <= TCAP_RESET_BYTE;
        end else if (bus.rd) begin
            unique case (bus.addr)
                TCAP_ADDR_MAIN_MODE: bus_rdata_out <= main_mode;
                TCAP_ADDR_MAIN_LOW: bus_rdata_out <= main_count[7:0];
                TCAP_ADDR_MAIN_HIGH: bus_rdata_out <= main_high_snap;
                TCAP_ADDR_CAP_MODE: bus_rdata_out <= {capture_enable,
                    3'b000, capture_overflow_select,
                    capture_go && active,
                    capture_function_select}; // R15 R16
                TCAP_ADDR_CAP_LOW: bus_rdata_out <= capture_count[7:0];
                TCAP_ADDR_CAP_HIGH: bus_rdata_out <= cap_high_snap; // R18
                TCAP_ADDR_FLAGS: bus_rdata_out <= {6'b000000,
                    main_timer_irq_enable, main_timer_flag};
                default: bus_rdata_out <= TCAP_RESET_BYTE;
            endcase
        end else begin
            bus_rdata_out <= TCAP_RESET_BYTE;
        end
    end
endmodule
`default_nettype wire

// ### bench/tcap_timer_asserts.sv
// Purpose: port checks for the capture timer
// Assumes: offsets and fields of tcap_pkg
// Notes: enable shadows are rebuilt from bus writes
`timescale 1ns/1ps
`default_nettype none
module tcap_timer_chk
    import tcap_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic [7:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [7:0] bus_rdata_out,
    input wire logic irq_out
);
    logic [2:0] sh; // main en, capture en, irq en
    logic rd_cm;
    assign rd_cm = bus_rd_in && bus_addr_in == TCAP_ADDR_CAP_MODE;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sh <= 3'h0;
        end else if (bus_wr_in) begin
            if (bus_addr_in == TCAP_ADDR_MAIN_MODE) sh[2] <= bus_wdata_in[7];
            if (bus_addr_in == TCAP_ADDR_CAP_MODE) sh[1] <= bus_wdata_in[7];
            if (bus_addr_in == TCAP_ADDR_FLAGS) sh[0] <= bus_wdata_in[1];
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);
    idle_rdata_a: assert property (!bus_rd_in |=> bus_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (
        bus_rd_in && bus_addr_in < TCAP_ADDR_FLAGS |=> bus_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    cap_mode_bits_a: assert property (
        rd_cm |=> (bus_rdata_out & ~TCAP_CM_MASK) == 8'h00)
        else $error("capture mode spare bits set");
    main_mode_bits_a: assert property (
        bus_rd_in && bus_addr_in == TCAP_ADDR_MAIN_MODE
        |=> (bus_rdata_out & ~TCAP_MM_MASK) == 8'h00)
        else $error("main mode spare bits set");
    go_refused_a: assert property (
        rd_cm && !(sh[2] && sh[1]) |=> !bus_rdata_out[TCAP_CM_GO])
        else $error("go reads one while disabled");
    irq_mirror_a: assert property (
        bus_rd_in && bus_addr_in == TCAP_ADDR_FLAGS
        |=> irq_out == (bus_rdata_out[0] & bus_rdata_out[1]))
        else $error("interrupt differs from flag and enable");
    irq_masked_a: assert property (!$past(sh[0]) |-> !irq_out)
        else $error("interrupt while masked");
    flag_clear_a: assert property (
        $fell(irq_out) |-> $past(bus_wr_in && bus_addr_in == TCAP_ADDR_FLAGS, 2))
        else $error("interrupt dropped without flag write");
    cover property (irq_out);
    cover property (rd_cm ##1 bus_rdata_out[TCAP_CM_GO]);
    cover property ($fell(irq_out));
endmodule
bind tcap_timer tcap_timer_chk i_chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_rdata_out(bus_rdata_out), .irq_out(irq_out));
`default_nettype wire

// ### bench/tcap_sig_model.sv
// Purpose: measured input signal with set high and low lengths
// Assumes: lengths in clock cycles, at least one
// Notes: push-pull source, so it holds idle_lvl_in when stopped
`timescale 1ns/1ps
`default_nettype none
module tcap_sig_model (
    input wire logic mclk_in,
    input wire logic run_in,
    input wire logic idle_lvl_in,
    input wire logic [7:0] high_len_in,
    input wire logic [7:0] low_len_in,
    output logic pin_out
);
    logic [7:0] cnt;
    initial pin_out = 1'b0;
    initial cnt = 8'h00;
    always @(posedge mclk_in) begin
        if (!run_in) begin
            pin_out <= idle_lvl_in;
            cnt <= 8'h00;
        end else if (cnt == (pin_out ? high_len_in : low_len_in) - 8'h01) begin
            pin_out <= ~pin_out;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### bench/test_t3_capture_timer.sv
// Purpose: register and measurement tests of the capture timer
// Assumes: fast clock tick every cycle, slow tick every second cycle
// Notes: widths expected in ticks of the chosen source
`timescale 1ns/1ps
`default_nettype none
module test_t3_capture_timer
    import tcap_pkg::*;
;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic cpu_tick = 1'b0;
    logic run = 1'b0;
    logic lvl = 1'b0;
    logic pin, irq;
    logic [7:0] rdata, hi = 8'h14, lo = 8'h1E;
    logic [15:0] w [1:3] = '{16'h0014, 16'h001E, 16'h0019};
    tcap_bus_t bus = '0;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    tcap_timer i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .cpu_tick_in(cpu_tick), .hosc_tick_in(1'b1),
        .capture_input_pin_in(pin), .bus_addr_in(bus.addr),
        .bus_wdata_in(bus.wdata), .bus_wr_in(bus.wr), .bus_rd_in(bus.rd),
        .bus_rdata_out(rdata), .irq_out(irq));
    tcap_sig_model i_sig (.mclk_in(mclk_in), .run_in(run),
        .idle_lvl_in(lvl), .high_len_in(hi), .low_len_in(lo), .pin_out(pin));
    always #2 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cpu_tick <= ~cpu_tick;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus.rd <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, e});
    endtask
    // low byte first, so the high byte comes from the snapshot
    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 8'h01, e[15:8]);
    endtask
    // counters loaded with the timer off, go raised last
    task automatic arm(input logic [7:0] fa, input logic [7:0] fd,
        input logic [15:0] mv, input logic [15:0] cv);
        wr(TCAP_ADDR_MAIN_MODE, 8'h00);
        wr(TCAP_ADDR_MAIN_HIGH, mv[15:8]);
        wr(TCAP_ADDR_MAIN_LOW, mv[7:0]);
        wr(TCAP_ADDR_CAP_HIGH, cv[15:8]);
        wr(TCAP_ADDR_CAP_LOW, cv[7:0]);
        wr(TCAP_ADDR_CAP_MODE, fd);
        wr(TCAP_ADDR_MAIN_MODE, fa);
        wr(TCAP_ADDR_CAP_MODE, fd | 8'h04);
        rd(TCAP_ADDR_CAP_MODE, fd | 8'h04);
        run <= 1'b1;
        for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge mclk_in);
        check({15'h0000, irq}, 16'h0001);
        run <= 1'b0;
        rd(TCAP_ADDR_CAP_MODE, fd);
        rd(TCAP_ADDR_FLAGS, 8'h03);
        wr(TCAP_ADDR_FLAGS, 8'h02);
        rd(TCAP_ADDR_FLAGS, 8'h02);
    endtask
    task automatic final_report();
        $display("compares %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        for (int a = 'hF9; a <= 'hFF; a++) rd(8'(a), 8'h00);
        rd(8'h10, 8'h00);
        wr(TCAP_ADDR_CAP_MODE, 8'hFF);
        rd(TCAP_ADDR_CAP_MODE, 8'h8B);
        wr(TCAP_ADDR_CAP_HIGH, 8'h12);
        wr(TCAP_ADDR_CAP_LOW, 8'h34);
        wr(TCAP_ADDR_CAP_HIGH, 8'h56);
        rd16(TCAP_ADDR_CAP_LOW, 16'h1234);
        wr(TCAP_ADDR_MAIN_MODE, 8'hF8);
        wr(TCAP_ADDR_CAP_MODE, 8'h85);
        wr(TCAP_ADDR_MAIN_MODE, 8'h00);
        rd(TCAP_ADDR_CAP_MODE, 8'h81);
        wr(TCAP_ADDR_FLAGS, 8'h02);
        // idle level sits inside the pulse, so that pulse is skipped
        for (logic [7:0] m = 8'h01; m < 8'h04; m++) begin
            lvl <= (m != 8'h02);
            arm(m == 8'h03 ? 8'hF0 : 8'hF8, 8'h80 | m, 16'h0000, 16'h0000);
            rd16(TCAP_ADDR_MAIN_LOW, w[m]);
        end
        lvl <= 1'b0;
        hi <= 8'h04;
        lo <= 8'h04;
        arm(8'hF8, 8'h80, 16'h0000, 16'hFFFD);
        rd16(TCAP_ADDR_MAIN_LOW, 16'h0010);
        rd16(TCAP_ADDR_CAP_LOW, 16'h0000);
        hi <= 8'h02;
        lo <= 8'h02;
        // gate of 15 ticks keeps an edge off the wrap cycle
        arm(8'hF8, 8'h88, 16'hFFF1, 16'h0000);
        rd16(TCAP_ADDR_MAIN_LOW, 16'h0000);
        rd16(TCAP_ADDR_CAP_LOW, 16'h0004);
        final_report();
    end
endmodule
`default_nettype wire
